// *** rtl/rsu_uart.sv ***
// serial port with byte register set, half-duplex direction control
`timescale 1ns/1ps
`default_nettype none
`include "rsu_cfg.svh"
module rsu_uart
	import rsu_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic [2:0] addr_i,
	input  wire logic       rd_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o,
	input  wire logic       rx_i,
	output logic            tx_o,
	output logic            rts_o,
	output logic            out1_o,
	output logic            irq_o,
	input  wire logic       rts_ctrl_fit_i,
	input  wire logic       duplex_echo_i
);
	// reference tick: phase accumulator gives 1.8432 MHz from 200 MHz
	localparam logic [31:0] REF_STEP = 32'(`RSU_REF_HZ);
	localparam logic [31:0] REF_MOD  = 32'(`RSU_CLK_HZ);
	logic [31:0] ref_acc_reg;
	logic        ref_tick_reg;
	logic [15:0] divisor_reg;
	logic [15:0] div_cnt_reg;
	logic        os_tick_reg;
	logic [7:0]  lcr_reg;
	logic [3:0]  mcr_reg;
	logic [7:0]  thr_reg;
	logic        thre_reg;
	logic [7:0]  rbr_reg;
	logic        dr_reg;
	logic        rx_sync;
	logic        ctl_fit_sync;
	logic        echo_sync;
	logic        das;
	logic [3:0]  nbits;
	logic        data_rd;
	logic        data_wr;

	assign das     = lcr_reg[`RSU_LCR_DAS];
	assign nbits   = 4'(`RSU_LEN_BASE) + {2'h0, lcr_reg[1:0]}; // (5..8)
	assign data_rd = rd_i && addr_i == `RSU_OFF_DATA && !das;
	assign data_wr = wr_i && addr_i == `RSU_OFF_DATA && !das;

	// pin and strap inputs pass two flops
	rsu_sync u_rx   (.clk_i(clk_i), .srst_i(srst_i), .d_i(rx_i),
		.rst_val_i(1'b1), .q_o(rx_sync));
	rsu_sync u_fit  (.clk_i(clk_i), .srst_i(srst_i), .d_i(rts_ctrl_fit_i),
		.rst_val_i(1'b1), .q_o(ctl_fit_sync));
	// echo off until the strap has settled, so reset never loops tx back
	rsu_sync u_echo (.clk_i(clk_i), .srst_i(srst_i), .d_i(duplex_echo_i),
		.rst_val_i(1'b0), .q_o(echo_sync));

	// reference clock emulation
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ref_acc_reg  <= 32'h0;
			ref_tick_reg <= 1'b0;
		end else if (ref_acc_reg + REF_STEP >= REF_MOD) begin
			ref_acc_reg  <= ref_acc_reg + REF_STEP - REF_MOD;
			ref_tick_reg <= 1'b1;
		end else begin
			ref_acc_reg  <= ref_acc_reg + REF_STEP;
			ref_tick_reg <= 1'b0;
		end
	end

	// divisor counter: one oversample tick per divisor reference ticks
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			div_cnt_reg <= 16'h0001;
			os_tick_reg <= 1'b0;
		end else if (ref_tick_reg) begin
			if (div_cnt_reg >= divisor_reg || divisor_reg == 16'h0000) begin
				div_cnt_reg <= 16'h0001;
				os_tick_reg <= 1'b1;
			end else begin
				div_cnt_reg <= div_cnt_reg + 16'h0001;
				os_tick_reg <= 1'b0;
			end
		end else begin
			os_tick_reg <= 1'b0;
		end
	end

	// divisor latch, only while divisor access is selected
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			divisor_reg <= `RSU_DIV_RESET;
		end else if (wr_i && das) begin
			if (addr_i == `RSU_OFF_DATA)
				divisor_reg[7:0] <= wdata_i;
			else if (addr_i == `RSU_OFF_DIVHI)
				divisor_reg[15:8] <= wdata_i;
		end
	end

	// line control and modem control
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			lcr_reg <= `RSU_LCR_RESET; // divisor select clear
			mcr_reg <= 4'h0;
		end else if (wr_i) begin
			if (addr_i == `RSU_OFF_LCR)
				lcr_reg <= wdata_i; // bits 3..6 kept, no parity logic
			if (addr_i == `RSU_OFF_MCR)
				mcr_reg <= wdata_i[3:0];
		end
	end

	// transmitter
	rsu_ser_e    tx_st_reg;
	logic [7:0]  tx_sh_reg;
	logic [3:0]  tx_os_reg;
	logic [3:0]  tx_bit_reg;
	logic        tx_line_reg;
	logic        tx_busy;
	assign tx_busy = tx_st_reg != RSU_IDLE;

	// holding register: host write loads and clears empty flag
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			thr_reg  <= 8'h00;
			thre_reg <= 1'b1;
		end else if (data_wr) begin
			thr_reg  <= wdata_i;
			thre_reg <= 1'b0;
		end else if (tx_st_reg == RSU_IDLE && !thre_reg) begin
			thre_reg <= 1'b1; // moved to shifter
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tx_st_reg   <= RSU_IDLE;
			tx_sh_reg   <= 8'h00;
			tx_os_reg   <= 4'h0;
			tx_bit_reg  <= 4'h0;
			tx_line_reg <= 1'b1;
		end else begin
			case (tx_st_reg)
				RSU_IDLE: begin
					tx_line_reg <= 1'b1;
					if (!thre_reg && !data_wr) begin
						tx_sh_reg <= thr_reg;
						tx_os_reg <= 4'h0;
						tx_st_reg <= RSU_START;
					end
				end
				RSU_START: begin
					tx_line_reg <= 1'b0;
					if (os_tick_reg) begin
						tx_os_reg <= tx_os_reg + 4'h1;
						if (tx_os_reg == 4'hF) begin
							tx_bit_reg <= 4'h0;
							tx_st_reg  <= RSU_DATA;
						end
					end
				end
				RSU_DATA: begin
					tx_line_reg <= tx_sh_reg[0];
					if (os_tick_reg) begin
						tx_os_reg <= tx_os_reg + 4'h1;
						if (tx_os_reg == 4'hF) begin
							tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
							tx_bit_reg <= tx_bit_reg + 4'h1;
							if (tx_bit_reg + 4'h1 == nbits) begin
								tx_bit_reg <= 4'h0;
								tx_st_reg  <= RSU_STOP;
							end
						end
					end
				end
				RSU_STOP: begin
					tx_line_reg <= 1'b1;
					if (os_tick_reg) begin
						tx_os_reg <= tx_os_reg + 4'h1;
						if (tx_os_reg == 4'hF) begin
							tx_bit_reg <= tx_bit_reg + 4'h1;
							// two stop bits when bit 2 set
							if (tx_bit_reg[0] || !lcr_reg[`RSU_LCR_STOP])
								tx_st_reg <= RSU_IDLE;
						end
					end
				end
				default: tx_st_reg <= RSU_IDLE;
			endcase
		end
	end

	// receiver; duplex echo feeds our own line back in
	rsu_ser_e    rx_st_reg;
	logic [7:0]  rx_sh_reg;
	logic [3:0]  rx_os_reg;
	logic [3:0]  rx_bit_reg;
	logic        rx_line;
	// in half-duplex without echo the receiver hears the wire only
	assign rx_line = (echo_sync && tx_busy) ? tx_line_reg : rx_sync;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rx_st_reg  <= RSU_IDLE;
			rx_sh_reg  <= 8'h00;
			rx_os_reg  <= 4'h0;
			rx_bit_reg <= 4'h0;
		end else begin
			case (rx_st_reg)
				RSU_IDLE: begin
					rx_os_reg <= 4'h0;
					if (!rx_line)
						rx_st_reg <= RSU_START;
				end
				RSU_START: begin
					if (os_tick_reg) begin
						rx_os_reg <= rx_os_reg + 4'h1;
						// mid-bit check rejects glitches
						if (rx_os_reg == 4'h7) begin
							if (rx_line) begin
								rx_st_reg <= RSU_IDLE;
							end else begin
								rx_os_reg  <= 4'h0;
								rx_bit_reg <= 4'h0;
								rx_st_reg  <= RSU_DATA;
							end
						end
					end
				end
				RSU_DATA: begin
					if (os_tick_reg) begin
						rx_os_reg <= rx_os_reg + 4'h1;
						if (rx_os_reg == 4'hF) begin
							rx_sh_reg  <= {rx_line, rx_sh_reg[7:1]};
							rx_bit_reg <= rx_bit_reg + 4'h1;
							if (rx_bit_reg + 4'h1 == nbits)
								rx_st_reg <= RSU_STOP;
						end
					end
				end
				RSU_STOP: begin
					if (os_tick_reg) begin
						rx_os_reg <= rx_os_reg + 4'h1;
						if (rx_os_reg == 4'hF)
							rx_st_reg <= RSU_IDLE;
					end
				end
				default: rx_st_reg <= RSU_IDLE;
			endcase
		end
	end

	// receive buffer; new character wins over a same-cycle read
	logic rx_done;
	assign rx_done = rx_st_reg == RSU_STOP && os_tick_reg && rx_os_reg == 4'hF;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rbr_reg <= 8'h00;
			dr_reg  <= 1'b0;
		end else if (rx_done) begin
			// right-justify short characters
			rbr_reg <= rx_sh_reg >> (4'h8 - nbits);
			dr_reg  <= 1'b1;
		end else if (data_rd) begin
			dr_reg <= 1'b0;
		end
	end

	// read data register
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				`RSU_OFF_DATA:  rdata_o <= das ? divisor_reg[7:0] : rbr_reg;
				`RSU_OFF_DIVHI: rdata_o <= das ? divisor_reg[15:8] : 8'h00;
				`RSU_OFF_IID:   rdata_o <= dr_reg ? `RSU_IID_RDA : `RSU_IID_NONE;
				`RSU_OFF_LCR:   rdata_o <= lcr_reg;
				`RSU_OFF_MCR:   rdata_o <= {4'h0, mcr_reg};
				`RSU_OFF_LSR:   rdata_o <= {1'b0, thre_reg && !tx_busy, thre_reg,
					4'h0, dr_reg};
				default:        rdata_o <= 8'h00;
			endcase
		end
	end

	// pins: direction control, user output, gated interrupt
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			tx_o   <= 1'b1;
			rts_o  <= 1'b0;
			out1_o <= 1'b0;
			irq_o  <= 1'b0;
		end else begin
			tx_o   <= tx_line_reg;
			// drives transceiver enable, not sent on the line
			rts_o  <= ctl_fit_sync ? mcr_reg[`RSU_MCR_RTS] : 1'b1;
			out1_o <= mcr_reg[`RSU_MCR_OUT1];
			irq_o  <= mcr_reg[`RSU_MCR_IRQEN] && dr_reg;
		end
	end
endmodule : rsu_uart
`default_nettype wire

// *** rtl/rsu_cfg.svh ***
// constants and rule summary for the serial register port
// How it works
// - line control bit 7 selects divisor latch at offsets 0 and 1.
// - divisor low byte at offset 0, high byte at offset 1.
// - bit rate is reference divided by sixteen times divisor.
// - line control bits 1:0 give data length minus five.
// - line control bit 2 chooses one or two stop bits.
// - line control bits 3 to 6 stored; parity and break unused.
// - modem control bit 1 drives request-to-send.
// - modem bit 2 is an output; bit 3 gates interrupt line.
// - reading offset 0 returns received byte and consumes it.
// - line status bit 0 shows a received byte waiting.
// - offset 2 reports highest pending interrupt source.
// - received data pending gives identification value 4.
// - nothing pending reads identification value exactly 1.
// - request-to-send steers transceiver direction only.
// - status bit 5 holding empty; data write loads and clears it.
// - without direction option, request-to-send stays high.
// - duplex mode echoes own transmission into receiver.
`ifndef RSU_CFG_SVH
`define RSU_CFG_SVH
`define RSU_OFF_DATA   3'h0
`define RSU_OFF_DIVHI  3'h1
`define RSU_OFF_IID    3'h2
`define RSU_OFF_LCR    3'h3
`define RSU_OFF_MCR    3'h4
`define RSU_OFF_LSR    3'h5
`define RSU_LCR_DAS    7
`define RSU_LCR_STOP   2
`define RSU_MCR_RTS    1
`define RSU_MCR_OUT1   2
`define RSU_MCR_IRQEN  3
`define RSU_LSR_DR     0
`define RSU_LSR_THRE   5
`define RSU_LSR_TEMT   6
`define RSU_IID_NONE   8'h01
`define RSU_IID_RDA    8'h04
`define RSU_OVERSAMPLE 16
`define RSU_LEN_BASE   5
`define RSU_REF_HZ     1843200
`define RSU_CLK_HZ     200000000
`define RSU_DIV_RESET  16'h000C
`define RSU_LCR_RESET  8'h03
`endif

// *** rtl/rsu_pkg.sv ***
// types for the serial register port
package rsu_pkg;
	typedef enum logic [3:0] {
		RSU_IDLE  = 4'b0001,
		RSU_START = 4'b0010,
		RSU_DATA  = 4'b0100,
		RSU_STOP  = 4'b1000
	} rsu_ser_e;
endpackage : rsu_pkg

// *** rtl/rsu_sync.sv ***
// two-stage synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module rsu_sync (
	input  wire logic clk_i,
	input  wire logic srst_i,
	input  wire logic d_i,
	input  wire logic rst_val_i,
	output var  logic q_o
);
	logic meta_reg;
	// first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_reg <= rst_val_i;
			q_o      <= rst_val_i;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule : rsu_sync
`default_nettype wire

// *** testbench/rsu_uart_chk.sv ***
// pin-level assertions for the serial register port
`timescale 1ns/1ps
`default_nettype none
module rsu_uart_chk (
	input wire logic       clk_i,
	input wire logic       srst_i,
	input wire logic [2:0] addr_i,
	input wire logic       rd_i,
	input wire logic       wr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic       rx_i,
	input wire logic       tx_o,
	input wire logic       rts_o,
	input wire logic       out1_o,
	input wire logic       irq_o,
	input wire logic       rts_ctrl_fit_i,
	input wire logic       duplex_echo_i
);
	logic [7:0]  lcr_reg;
	logic [7:0]  mcr_reg;
	logic [15:0] div_reg;
	logic [3:0]  quiet_reg;
	logic        fit_reg;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// shadow of the host-written control registers
	always_ff @(posedge clk_i) begin
		fit_reg <= rts_ctrl_fit_i;
		if (srst_i) begin
			lcr_reg <= 8'h03;
			mcr_reg <= 8'h00;
			div_reg <= 16'h000C;
		end else if (wr_i) begin
			if (addr_i == 3'h3) lcr_reg <= wdata_i;
			if (addr_i == 3'h4) mcr_reg <= wdata_i;
			if (addr_i == 3'h0 && lcr_reg[7]) div_reg[7:0] <= wdata_i;
			if (addr_i == 3'h1 && lcr_reg[7]) div_reg[15:8] <= wdata_i;
		end
	end
	// cycles since the pins last had cause to move; straps pass two flops
	always_ff @(posedge clk_i) begin
		if (srst_i || (wr_i && addr_i == 3'h4) || fit_reg != rts_ctrl_fit_i) quiet_reg <= 4'h0;
		else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
	end
	reset_idle_a: assert property ($fell(srst_i) |-> tx_o && !rts_o && !out1_o && !irq_o)
		else $error("pins not idle after reset");
	rts_dir_a: assert property (quiet_reg > 4'h4 |-> rts_o == (fit_reg ? mcr_reg[1] : 1'b1))
		else $error("direction pin wrong");
	user_out_a: assert property (quiet_reg > 4'h4 |-> out1_o == mcr_reg[2])
		else $error("user output wrong");
	irq_gate_a: assert property (quiet_reg > 4'h4 && !mcr_reg[3] |-> !irq_o)
		else $error("interrupt not gated");
	iid_value_a: assert property (rd_i && addr_i == 3'h2 |=> rdata_o inside {8'h01, 8'h04})
		else $error("bad identification value");
	iid_pend_a: assert property (rd_i && addr_i == 3'h2 && irq_o && !$past(rd_i) |=> rdata_o == 8'h04)
		else $error("pending data not identified");
	div_read_a: assert property (rd_i && lcr_reg[7] && addr_i < 3'h2
		|=> rdata_o == ($past(addr_i) == 3'h1 ? div_reg[15:8] : div_reg[7:0]))
		else $error("divisor readback wrong");
	lcr_read_a: assert property (rd_i && addr_i == 3'h3 |=> rdata_o == lcr_reg)
		else $error("line control readback wrong");
	tx_busy_a: assert property (wr_i && addr_i == 3'h0 && !lcr_reg[7] ##2 rd_i && addr_i == 3'h5
		|=> !rdata_o[6])
		else $error("transmitter idle after load");
	cover property (irq_o);
	cover property (!tx_o);
	cover property (quiet_reg > 4'h4 && !fit_reg && rts_o);
endmodule : rsu_uart_chk
bind rsu_uart rsu_uart_chk rsu_uart_chk_i (.*);
`default_nettype wire

// *** testbench/rsu_node.sv ***
// behavioural remote node on the differential line
`timescale 1ns/1ps
`default_nettype none
module rsu_node #(parameter realtime BIT_NS = 8680.556) (
	input  wire logic       line_i,
	input  wire logic [3:0] nbits_i,
	output var  logic       line_o,
	output var  logic [7:0] got_o
);
	// biased line rests high between frames
	initial line_o = 1'b1;
	// sample mid-bit, lsb first; stop bits are not judged here
	always @(negedge line_i) begin
		#(BIT_NS / 2);
		got_o = 8'h00;
		for (int i = 0; i < nbits_i; i++) begin
			#(BIT_NS);
			got_o[i] = line_i;
		end
		#(BIT_NS);
	end
	task automatic send(input logic [7:0] b, input int n);
		line_o = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < n; i++) begin
			line_o = b[i];
			#(BIT_NS);
		end
		line_o = 1'b1;
		#(BIT_NS);
	endtask : send
endmodule : rsu_node
`default_nettype wire

// *** testbench/rs485_uart_register_port_bench.sv ***
// self-checking bench for the serial register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module rs485_uart_register_port_bench;
	logic       clk_i = 1'b0;
	logic       srst_i = 1'b1;
	logic [2:0] addr_i = 3'h0;
	logic       rd_i = 1'b0;
	logic       wr_i = 1'b0;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o;
	logic       rx_i;
	logic       tx_o;
	logic       rts_o;
	logic       out1_o;
	logic       irq_o;
	logic       rts_ctrl_fit_i = 1'b1;
	logic       duplex_echo_i = 1'b0;
	logic [3:0] nbits = 4'd5;
	logic [7:0] got;
	int         err_count = 0;
	int         checked = 0;
	int         cycles = 0;
	rsu_uart rsu_uart_i (.*);
	rsu_node node_i (.line_i(tx_o), .nbits_i(nbits), .line_o(rx_i), .got_o(got));
	// 200 MHz
	always #2.5 clk_i = ~clk_i;
	task automatic finish_test;
		if (err_count == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// host cycles: one strobe, then an idle edge so strobes never merge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		v = rdata_o;
	endtask : rd
	task automatic wait_lsr(input int b);
		logic [7:0] v;
		v = 8'h00;
		while (!v[b]) rd(3'h5, v);
	endtask : wait_lsr
	task automatic t_reset;
		logic [7:0] v;
		rd(3'h3, v);
		`CHK("lcr", 8'h03, v)
		rd(3'h4, v);
		`CHK("mcr", 8'h00, v)
		rd(3'h2, v);
		`CHK("iid", 8'h01, v)
		rd(3'h5, v);
		`CHK("lsr", 8'h60, v & 8'h61)
		rd(3'h6, v);
		`CHK("gap", 8'h00, v)
		`CHK("rts", 1'b0, rts_o)
	endtask : t_reset
	task automatic t_div;
		logic [7:0] v;
		wr(3'h3, 8'hFB);
		wr(3'h0, 8'h01);
		wr(3'h1, 8'hA5);
		rd(3'h1, v);
		`CHK("div_hi", 8'hA5, v)
		wr(3'h1, 8'h00);
		rd(3'h0, v);
		`CHK("div_lo", 8'h01, v)
		rd(3'h3, v);
		`CHK("lcr_all", 8'hFB, v)
		wr(3'h3, 8'h00);
		rd(3'h1, v);
		`CHK("no_ier", 8'h00, v)
	endtask : t_div
	// five-bit characters, second loaded only once the holder empties
	task automatic t_tx;
		logic [7:0] v;
		wr(3'h4, 8'h02);
		repeat (6) @(posedge clk_i);
		`CHK("rts_on", 1'b1, rts_o)
		for (int i = 0; i < 2; i++) begin
			wait_lsr(5);
			wr(3'h0, 8'h35 >> i);
			rd(3'h5, v);
			`CHK("busy", 8'h00, v & 8'h40)
			wait_lsr(6);
			`CHK("tx5", (8'h35 >> i) & 8'h1F, got)
		end
		wr(3'h4, 8'h00);
	endtask : t_tx
	task automatic t_rx;
		logic [7:0] v;
		wr(3'h3, 8'h03);
		wr(3'h4, 8'h08);
		node_i.send(8'hA7, 8);
		repeat (4) @(posedge clk_i);
		`CHK("rts_off", 1'b0, rts_o)
		`CHK("irq", 1'b1, irq_o)
		rd(3'h5, v);
		`CHK("dr", 8'h01, v & 8'h01)
		rd(3'h2, v);
		`CHK("iid_rx", 8'h04, v)
		rd(3'h0, v);
		`CHK("rx8", 8'hA7, v)
		rd(3'h0, v);
		rd(3'h5, v);
		`CHK("dr_clr", 8'h00, v & 8'h01)
		rd(3'h2, v);
		`CHK("iid_none", 8'h01, v)
	endtask : t_rx
	// direction option absent and echo strapped on
	task automatic t_echo;
		logic [7:0] v;
		int         c0;
		rts_ctrl_fit_i <= 1'b0;
		duplex_echo_i <= 1'b1;
		nbits = 4'd8;
		wr(3'h4, 8'h04);
		repeat (6) @(posedge clk_i);
		`CHK("rts_free", 1'b1, rts_o)
		`CHK("out1", 1'b1, out1_o)
		// eight bits, two stop bits: eleven bit times, one-stop frame is ten
		wr(3'h3, 8'h07);
		c0 = cycles;
		wr(3'h0, 8'h5C);
		wait_lsr(6);
		`CHK("tx8", 8'h5C, got)
		`CHK("two_stop", 1'b1, (cycles - c0) > 18500)
		wait_lsr(0);
		`CHK("irq_off", 1'b0, irq_o)
		rd(3'h0, v);
		`CHK("echo", 8'h5C, v)
	endtask : t_echo
	// cut a hang short; the run needs about 62k cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 90000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		t_reset();
		t_div();
		t_tx();
		t_rx();
		t_echo();
		finish_test();
	end
endmodule : rs485_uart_register_port_bench
`default_nettype wire
